// file: pbs_regs.vh
// Register map and field constants for the power budget and switch status slice
`ifndef PBS_REGS_VH
`define PBS_REGS_VH

`define PBS_ADDR_W 12
`define PBS_DATA_W 32

`define PBS_OFF_SELECT 12'h284
`define PBS_OFF_READOUT 12'h288
`define PBS_OFF_ALLOC 12'h28c
`define PBS_OFF_WORD_BASE 12'h300
`define PBS_OFF_WORD_LAST 12'h324
`define PBS_OFF_STATUS 12'h328
`define PBS_OFF_CONTROL 12'h32c

`define PBS_WORD_COUNT 10
`define PBS_WORD_MAX_IDX 8'h09
`define PBS_IDX_W 8

`define PBS_ALLOC_FLAG_BIT 0
`define PBS_CTL_REG_UNLOCK_BIT 3
`define PBS_CTL_VAL_UNLOCK_BIT 4

`define PBS_STS_MODE_LSB 0
`define PBS_STS_DS_BIT 5
`define PBS_STS_US_BIT 6
`define PBS_STS_HALT_BIT 9
`define PBS_STS_LOCK_LSB 20
`define PBS_STS_MARKER_LSB 28

`define PBS_RST_SELECT 8'h00
`define PBS_RST_ALLOC 1'b0
`define PBS_RST_MARKER 4'h0
`define PBS_RST_VAL_UNLOCK 1'b0
`define PBS_RST_REG_UNLOCK 1'b1

`define PBS_RESP_OKAY 2'b00
`define PBS_RESP_SLVERR 2'b10

`endif

// file: pbs_regs.v
// Power budget capability and switch status register slice with an AXI4-Lite slave
//
// Function
// - Select register bits 7:0 hold read-write budget index, reset zero.
// - Index above 9 makes the readout register return all zeros.
// - Readout register is read-only, returns selected budget word or zero.
// - Allocation bit 0 is sticky, lock-protected system allocated flag, reset zero.
// - Budget words written only while budget value unlock is set.
// - Ten sticky 32-bit budget words from 0x300, no reset value forced.
// - Status bits 2:0 report operating select pins; 0 normal, 1 with memory init.
// - Status bit 5 holds downstream shared refclk pin captured at fundamental reset.
// - Status bit 6 holds upstream shared refclk pin captured at fundamental reset.
// - Status bit 9 holds hold in reset pin captured at fundamental reset.
// - Status bits 22:20 report upstream lock owner code.
// - Status bits 31:28 sticky lock-protected marker, reset zero, kept on hot reset.
// - Budget value unlock is switch control bit 4, sticky, lock-protected, reset zero.
// - Lock-protected fields writable only while control bit 3 set; reset sets it.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_regs.vh"

module pbs_regs (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    input wire hot_reset,
    // Strap and status pins
    input wire [2:0] operating_select_pins,
    input wire downstream_shared_refclk,
    input wire upstream_shared_refclk,
    input wire hold_in_reset,
    input wire [2:0] upstream_lock_owner,
    // AXI4-Lite write address
    input wire [`PBS_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [`PBS_DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [`PBS_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [`PBS_DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // Register state
    reg [`PBS_IDX_W-1:0] budget_index_q;
    reg system_allocated_flag_q;
    reg [3:0] marker_q;
    reg register_write_unlock_q;
    reg budget_value_write_unlock_q;
    reg [2:0] lock_owner_q;
    reg [31:0] budget_word [0:`PBS_WORD_COUNT-1];

    // Strap capture
    reg [5:0] pin_s1_q;
    reg [5:0] pin_s2_q;
    reg [5:0] pin_s3_q;
    reg strap_pending_q;
    reg [2:0] op_mode_q;
    reg ds_refclk_q;
    reg us_refclk_q;
    reg halt_q;

    // Write channel holding
    reg [`PBS_ADDR_W-1:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg aw_held_q;
    reg w_held_q;

    wire do_write;
    wire [3:0] wword;
    wire word_we;

    function addr_mapped;
        input [`PBS_ADDR_W-1:0] a;
        begin
            addr_mapped = (a[1:0] == 2'b00) &&
                ((a == `PBS_OFF_SELECT) || (a == `PBS_OFF_READOUT) || (a == `PBS_OFF_ALLOC) ||
                 (a == `PBS_OFF_STATUS) || (a == `PBS_OFF_CONTROL) ||
                 ((a >= `PBS_OFF_WORD_BASE) && (a <= `PBS_OFF_WORD_LAST)));
        end
    endfunction

    function [3:0] word_slot;
        input [`PBS_ADDR_W-1:0] a;
        reg [`PBS_ADDR_W-1:0] diff;
        begin
            diff = a - `PBS_OFF_WORD_BASE;
            word_slot = diff[5:2];
        end
    endfunction

    function is_word;
        input [`PBS_ADDR_W-1:0] a;
        begin
            is_word = (a[1:0] == 2'b00) && (a >= `PBS_OFF_WORD_BASE) && (a <= `PBS_OFF_WORD_LAST);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    function [31:0] read_value;
        input [`PBS_ADDR_W-1:0] a;
        begin
            read_value = 32'h0000_0000;
            if (a == `PBS_OFF_SELECT) begin
                read_value = {24'h00_0000, budget_index_q};
            end else if (a == `PBS_OFF_READOUT) begin
                if (budget_index_q <= `PBS_WORD_MAX_IDX) begin
                    read_value = budget_word[budget_index_q[3:0]];
                end else begin
                    read_value = 32'h0000_0000;
                end
            end else if (a == `PBS_OFF_ALLOC) begin
                read_value = {31'h0000_0000, system_allocated_flag_q};
            end else if (is_word(a)) begin
                read_value = budget_word[word_slot(a)];
            end else if (a == `PBS_OFF_STATUS) begin
                read_value = {marker_q, 5'h00, lock_owner_q, 10'h000, halt_q, 2'b00,
                              us_refclk_q, ds_refclk_q, 2'b00, op_mode_q};
            end else if (a == `PBS_OFF_CONTROL) begin
                read_value = {27'h000_0000, budget_value_write_unlock_q, register_write_unlock_q, 3'b000};
            end
        end
    endfunction

    // Pin synchronisers; only the second and third stages are compared
    always @(posedge clk_sys) begin
        pin_s1_q <= {hold_in_reset, upstream_shared_refclk, downstream_shared_refclk, operating_select_pins};
        pin_s2_q <= pin_s1_q;
        pin_s3_q <= pin_s2_q;
    end

    // Straps are caught once after fundamental reset, when the pins have settled
    // Hot reset never resamples them; a strap change needs a fundamental reset
    always @(posedge clk_sys) begin
        if (srst) begin
            strap_pending_q <= 1'b1;
            op_mode_q <= 3'h0;
            ds_refclk_q <= 1'b0;
            us_refclk_q <= 1'b0;
            halt_q <= 1'b0;
        end else if (strap_pending_q && (pin_s2_q == pin_s3_q)) begin
            strap_pending_q <= 1'b0;
            op_mode_q <= pin_s3_q[2:0];
            ds_refclk_q <= pin_s3_q[3];
            us_refclk_q <= pin_s3_q[4];
            halt_q <= pin_s3_q[5];
        end
    end

    // Lock owner comes from core logic on this clock
    always @(posedge clk_sys) begin
        if (srst) begin
            lock_owner_q <= 3'h0;
        end else begin
            lock_owner_q <= upstream_lock_owner;
        end
    end

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wword = word_slot(waddr_q);
    // Words are lock-protected too, so the value unlock alone does not open a sealed slice
    assign word_we = do_write && is_word(waddr_q) && register_write_unlock_q && budget_value_write_unlock_q;

    // Write address and data are taken independently and held until the response
    always @(posedge clk_sys) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= {`PBS_ADDR_W{1'b0}};
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PBS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q <= s_axi_awaddr;
                aw_held_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_held_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(waddr_q) ? `PBS_RESP_OKAY : `PBS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Index is not sticky: both resets clear it
    always @(posedge clk_sys) begin
        if (srst || hot_reset) begin
            budget_index_q <= `PBS_RST_SELECT;
        end else if (do_write && (waddr_q == `PBS_OFF_SELECT) && wstrb_q[0]) begin
            budget_index_q <= wdata_q[7:0];
        end
    end

    // Sticky fields: only fundamental reset clears them, hot reset leaves them
    always @(posedge clk_sys) begin
        if (srst) begin
            system_allocated_flag_q <= `PBS_RST_ALLOC;
            marker_q <= `PBS_RST_MARKER;
            budget_value_write_unlock_q <= `PBS_RST_VAL_UNLOCK;
        end else if (do_write && register_write_unlock_q) begin
            if ((waddr_q == `PBS_OFF_ALLOC) && wstrb_q[0]) begin
                system_allocated_flag_q <= wdata_q[`PBS_ALLOC_FLAG_BIT];
            end
            if ((waddr_q == `PBS_OFF_STATUS) && wstrb_q[3]) begin
                marker_q <= wdata_q[31:`PBS_STS_MARKER_LSB];
            end
            if ((waddr_q == `PBS_OFF_CONTROL) && wstrb_q[0]) begin
                budget_value_write_unlock_q <= wdata_q[`PBS_CTL_VAL_UNLOCK_BIT];
            end
        end
    end

    // Reset operation opens the locked fields so the loader can fill them
    always @(posedge clk_sys) begin
        if (srst || hot_reset) begin
            register_write_unlock_q <= `PBS_RST_REG_UNLOCK;
        end else if (do_write && (waddr_q == `PBS_OFF_CONTROL) && wstrb_q[0]) begin
            register_write_unlock_q <= wdata_q[`PBS_CTL_REG_UNLOCK_BIT];
        end
    end

    // Budget words carry no reset so their content survives every reset
    always @(posedge clk_sys) begin
        if (!srst && word_we) begin
            budget_word[wword] <= merge(budget_word[wword], wdata_q, wstrb_q);
        end
    end

    // Read channel: one read outstanding, data sampled at the address handshake
    always @(posedge clk_sys) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PBS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_value(s_axi_araddr);
                s_axi_rresp <= addr_mapped(s_axi_araddr) ? `PBS_RESP_OKAY : `PBS_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// file: pbs_regs_properties.sv
// Assertion checker for the power budget and switch status register slice
`timescale 1ns/1ps
`default_nettype none
`include "pbs_regs.vh"
module pbs_regs_properties (
    // Clock, reset and pins
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [2:0] upstream_lock_owner,
    // Read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Write response
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic ar_go = s_axi_arvalid && s_axi_arready;
    read_answer_a: assert property (ar_go |=> s_axi_rvalid)
        else $error("read not answered");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not retired");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");
    select_rsvd_a: assert property (ar_go && s_axi_araddr == `PBS_OFF_SELECT |=> s_axi_rdata[31:8] == 24'h0)
        else $error("select upper bits set");
    alloc_rsvd_a: assert property (ar_go && s_axi_araddr == `PBS_OFF_ALLOC |=> s_axi_rdata[31:1] == 31'h0)
        else $error("allocation upper bits set");
    status_rsvd_a: assert property (ar_go && s_axi_araddr == `PBS_OFF_STATUS
        |=> (s_axi_rdata & 32'h0f8f_fd98) == 0) else $error("status reserved bits set");
    control_rsvd_a: assert property (ar_go && s_axi_araddr == `PBS_OFF_CONTROL
        |=> (s_axi_rdata & 32'hffff_ffe7) == 0) else $error("control reserved bits set");
    // Straight after reset the owner flop may not have caught up yet
    lock_owner_a: assert property (ar_go && s_axi_araddr == `PBS_OFF_STATUS && $stable(upstream_lock_owner)
        && !$past(srst) |=> s_axi_rdata[22:20] == $past(upstream_lock_owner)) else $error("lock owner wrong");
    unmapped_a: assert property (ar_go && s_axi_araddr == 12'h000
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answered wrongly");
    cover property (s_axi_bvalid && s_axi_bresp == `PBS_RESP_SLVERR);
    cover property (ar_go && s_axi_araddr == `PBS_OFF_READOUT);
    cover property (ar_go && s_axi_araddr == `PBS_OFF_STATUS);
endmodule
bind pbs_regs pbs_regs_properties i_props (
    .clk_sys(clk_sys), .srst(srst), .upstream_lock_owner(upstream_lock_owner), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready)
);
`default_nettype wire

// file: test_pbs_regs.sv
// Self-checking testbench for the power budget and switch status register slice
`timescale 1ns/1ps
`default_nettype none
`include "pbs_regs.vh"
module test_pbs_regs;
    logic clk_sys = 0, srst = 1, hot_reset = 0, ds = 1, us = 0, halt = 1;
    logic [2:0] opsel = 3'h1, owner = 3'h2;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_errors = 0, total_checks = 0, cycles = 0, i;
    pbs_regs i_dut (.clk_sys(clk_sys), .srst(srst), .hot_reset(hot_reset), .operating_select_pins(opsel),
        .downstream_shared_refclk(ds), .upstream_shared_refclk(us), .hold_in_reset(halt),
        .upstream_lock_owner(owner), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // A leading edge keeps a new request clear of the previous release
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge clk_sys);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk_sys);
        rready <= 1'b0;
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, er});
    endtask
    function automatic logic [31:0] word(input int k);
        return 32'h5a00_0000 + k * 32'h0001_0203;
    endfunction
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        rd(`PBS_OFF_SELECT, 32'h0, 2'b00);
        rd(`PBS_OFF_ALLOC, 32'h0, 2'b00);
        rd(`PBS_OFF_CONTROL, 32'h08, 2'b00);
        rd(`PBS_OFF_STATUS, 32'h0020_0221, 2'b00);
        owner <= 3'h3;
        ds <= 1'b0;
        us <= 1'b1;
        halt <= 1'b0;
        rd(`PBS_OFF_STATUS, 32'h0030_0221, 2'b00);
        wr(`PBS_OFF_SELECT, 32'hffff_ffff, 2'b00);
        rd(`PBS_OFF_SELECT, 32'h0000_00ff, 2'b00);
        wr(`PBS_OFF_CONTROL, 32'h18, 2'b00);
        for (i = 0; i < 10; i++) wr(12'h300 + 12'(4 * i), word(i), 2'b00);
        for (i = 0; i < 13; i++) begin
            wr(`PBS_OFF_SELECT, (i == 12) ? 32'hff : i, 2'b00);
            rd(`PBS_OFF_READOUT, (i < 10) ? word(i) : 32'h0, 2'b00);
        end
        wr(`PBS_OFF_CONTROL, 32'h08, 2'b00);
        wr(12'h30c, 32'h0, 2'b00);
        wr(`PBS_OFF_SELECT, 32'h3, 2'b00);
        wr(`PBS_OFF_READOUT, 32'h0, 2'b00);
        rd(`PBS_OFF_READOUT, word(3), 2'b00);
        wr(`PBS_OFF_CONTROL, 32'h10, 2'b00);
        wr(12'h30c, 32'h0, 2'b00);
        rd(12'h30c, word(3), 2'b00);
        wr(`PBS_OFF_ALLOC, 32'h1, 2'b00);
        wr(`PBS_OFF_STATUS, 32'hf000_0000, 2'b00);
        wr(`PBS_OFF_CONTROL, 32'h00, 2'b00);
        rd(`PBS_OFF_ALLOC, 32'h0, 2'b00);
        rd(`PBS_OFF_CONTROL, 32'h10, 2'b00);
        rd(`PBS_OFF_STATUS, 32'h0030_0221, 2'b00);
        wr(`PBS_OFF_CONTROL, 32'h08, 2'b00);
        wr(`PBS_OFF_ALLOC, 32'hffff_ffff, 2'b00);
        wr(`PBS_OFF_STATUS, 32'ha000_0000, 2'b00);
        @(posedge clk_sys);
        hot_reset <= 1'b1;
        @(posedge clk_sys);
        hot_reset <= 1'b0;
        rd(`PBS_OFF_SELECT, 32'h0, 2'b00);
        rd(`PBS_OFF_ALLOC, 32'h1, 2'b00);
        rd(`PBS_OFF_CONTROL, 32'h18, 2'b00);
        rd(`PBS_OFF_STATUS, 32'ha030_0221, 2'b00);
        rd(12'h000, 32'h0, `PBS_RESP_SLVERR);
        wr(12'h004, 32'h1, `PBS_RESP_SLVERR);
        print_verdict();
    end
endmodule
`default_nettype wire
